/* File: core/config_unit_cfg.svh */
`ifndef CONFIG_UNIT_CFG_SVH
`define CONFIG_UNIT_CFG_SVH

`define ERR_NONE 3'h0
`define ERR_CRC 3'h1
`define ERR_SCRUB 3'h2
`define ERR_OTHER 3'h4
`define MODE_IDLE 4'h0
`define MODE_FULL 4'h1
`define MODE_PARTIAL 4'h2
`define STRAP_GATE_BIT 0
`define CLEAR_NS 1000
`define CLK_PERIOD_NS 25
`define CLEAR_CYCLES ((`CLEAR_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLEAR_CNT_W 6
`define SETTLE_CYCLES 2
`define CLKSEL_JTAG 1'b0
`define CLKSEL_HOST 1'b1

`endif

/* File: core/config_unit_pkg.sv */
`default_nettype none
package config_unit_pkg;
  typedef enum logic [5:0] {
    ST_CLEAR = 6'h01,
    ST_READY = 6'h02,
    ST_LOAD = 6'h04,
    ST_WAIT_DONE = 6'h08,
    ST_USER = 6'h10,
    ST_ERROR = 6'h20
  } cfg_state_t;
  typedef logic [2:0] err_code_t;
  typedef logic [3:0] mode_sel_t;
endpackage
`default_nettype wire

/* File: core/pin_sync.sv */
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] asyncIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // The first stage is read only by the second stage to contain metastability.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= asyncIn;
      stage2_ff <= stage1_ff;
    end
  end

  assign syncOut = stage2_ff;
endmodule
`default_nettype wire

/* File: core/clock_route.sv */
`default_nettype none
`include "config_unit_cfg.svh"
module clock_route (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clockSelect,
  input wire logic sysclkBypass,
  output logic selHostClk_ff,
  output logic bypassActive_ff
);
  logic nxtSelHostClk;
  logic nxtBypassActive;

  always_comb begin
    nxtSelHostClk = (clockSelect == `CLKSEL_HOST);
    nxtBypassActive = sysclkBypass;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      selHostClk_ff <= 1'b0;
      bypassActive_ff <= 1'b0;
    end else begin
      selHostClk_ff <= nxtSelHostClk;
      bypassActive_ff <= nxtBypassActive;
    end
  end
endmodule
`default_nettype wire

/* File: core/config_unit.sv */
// How it works
// - Configuration clock comes from JTAG clock or host clock, per clock select.
// - Bypass input high skips internal system clock; with select picks programming clock.
// - Three-bit active-high error code reports CRC, scrub or other load errors.
// - Error code sticks once set; loading never completes, user mode never entered.
// - Done released high only after a successful load, ready for user mode.
// - Done stays high until power cycle or re-initialisation reset.
// - A full-load configuration error keeps done low; a partial-reload error leaves done high.
// - Others may hold done low; unit proceeds only once done reads high.
// - Partial done released high after every successful load, full or partial reconfiguration.
// - Unit stalls while either done line reads low.
// - Four-bit mode select chooses the unit operating mode.
// - Active-low reset acts asynchronously, clearing memory and unit logic.
// - Test strap bit 0 gates host chip select to test control.
// - Transceiver test select routes JTAG pins to transceiver test controller.
// - Status released high after start-up and memory clear, awaiting commands.
// - Status holds high until power cycle, reset, or CRC error.
// - User-mode output high once user mode entered, until reset.
`default_nettype none
`include "config_unit_cfg.svh"
module config_unit
  import config_unit_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic config_clock_select,
  input wire logic config_sysclk_bypass,
  input wire config_unit_pkg::mode_sel_t config_mode_select,
  input wire logic [2:0] test_strap,
  input wire logic serdes_test_select,
  input wire logic host_chip_select_n,
  input wire logic testChipSelectN,
  input wire logic loadStart,
  input wire logic loadComplete,
  input wire logic crcError,
  input wire logic scrubError,
  input wire logic otherError,
  input wire logic config_done_in,
  input wire logic partial_reconfig_done_in,
  input wire logic jtagTck,
  input wire logic jtagTms,
  input wire logic jtagTdi,
  output logic selHostClk,
  output logic sysclkBypassed,
  output config_unit_pkg::err_code_t config_error_code,
  output logic config_done_out,
  output logic config_done_oe_n,
  output logic partial_reconfig_done_out,
  output logic partial_reconfig_done_oe_n,
  output logic config_ready_status_out,
  output logic config_ready_status_oe_n,
  output logic user_mode_flag,
  output logic memClear,
  output logic hostSelectN,
  output logic jtagToSerdes,
  output logic serdesTck,
  output logic serdesTms,
  output logic serdesTdi,
  output config_unit_pkg::mode_sel_t activeMode
);
  import config_unit_pkg::*;

  logic [3:0] modeSync;
  logic [2:0] strapSync;
  logic [6:0] pinSync;
  logic [2:0] jtagSync;
  logic doneHigh;
  logic partialHigh;
  logic startReq;
  logic loadOk;
  logic anyErr;

  cfg_state_t state_ff;
  cfg_state_t nxt_state;
  logic [`CLEAR_CNT_W-1:0] clearCnt_ff;
  logic [`CLEAR_CNT_W-1:0] nxt_clearCnt;
  err_code_t err_ff;
  err_code_t nxt_err;
  logic partialRun_ff;
  logic nxt_partialRun;
  logic partialDone_ff;
  logic nxt_partialDone;
  logic status_ff;
  logic nxt_status;
  logic user_ff;
  logic nxt_user;
  logic doneRel_ff;
  logic nxt_doneRel;
  mode_sel_t mode_ff;
  mode_sel_t nxt_mode;
  logic csn_ff;
  logic nxt_csn;
  logic route_ff;
  logic nxt_route;
  logic [2:0] jtagOut_ff;
  logic [2:0] nxt_jtagOut;
  logic odLevel_ff;
  logic nxt_odLevel;

  // Strap and control pins arrive from the board, so each is synchronised first.
  pin_sync #(.W(4)) u_mode_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(config_mode_select),
    .syncOut(modeSync)
  );

  pin_sync #(.W(3)) u_strap_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn(test_strap),
    .syncOut(strapSync)
  );

  // Chip selects pass inverted, so a freshly reset synchroniser reads as deselected.
  pin_sync #(.W(7)) u_pin_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn({serdes_test_select, ~host_chip_select_n, ~testChipSelectN,
              config_done_in, partial_reconfig_done_in, config_clock_select,
              config_sysclk_bypass}),
    .syncOut(pinSync)
  );

  pin_sync #(.W(3)) u_jtag_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .asyncIn({jtagTck, jtagTms, jtagTdi}),
    .syncOut(jtagSync)
  );

  clock_route u_clock_route (
    .mclk(mclk),
    .rst_n(rst_n),
    .clockSelect(pinSync[1]),
    .sysclkBypass(pinSync[0]),
    .selHostClk_ff(selHostClk),
    .bypassActive_ff(sysclkBypassed)
  );

  assign doneHigh = pinSync[3];
  assign partialHigh = pinSync[2];
  assign startReq = loadStart && (modeSync != `MODE_IDLE);
  assign loadOk = loadComplete && !anyErr;
  assign anyErr = crcError || scrubError || otherError;

  function automatic err_code_t encodeErr(input logic crc, input logic scrub,
                                         input logic other);
    err_code_t e;
    e = `ERR_NONE;
    if (crc) e = e | `ERR_CRC;
    if (scrub) e = e | `ERR_SCRUB;
    if (other) e = e | `ERR_OTHER;
    return e;
  endfunction

  // A partial image only makes sense on top of a full one, so each start decodes its mode.
  function automatic logic isFullMode(input mode_sel_t m);
    return m == `MODE_FULL;
  endfunction

  function automatic logic isPartialMode(input mode_sel_t m);
    return m == `MODE_PARTIAL;
  endfunction

  always_comb begin
    nxt_state = state_ff;
    nxt_clearCnt = clearCnt_ff;
    nxt_err = err_ff;
    nxt_partialRun = partialRun_ff;
    nxt_partialDone = partialDone_ff;
    nxt_status = status_ff;
    nxt_user = user_ff;
    nxt_doneRel = doneRel_ff;
    nxt_mode = modeSync;
    if (state_ff == ST_LOAD) begin
      nxt_err = err_ff | encodeErr(crcError, scrubError, otherError);
    end
    unique case (state_ff)
      ST_CLEAR: begin
        nxt_clearCnt = clearCnt_ff + `CLEAR_CNT_W'(1);
        if (clearCnt_ff == `CLEAR_CNT_W'(`CLEAR_CYCLES - 1)) begin
          nxt_state = ST_READY;
          nxt_status = 1'b1;
        end
      end
      ST_READY: begin
        if (startReq && isFullMode(modeSync)) begin
          nxt_state = ST_LOAD;
          nxt_partialRun = 1'b0;
          nxt_partialDone = 1'b0;
        end
      end
      ST_LOAD: begin
        if (anyErr) begin
          nxt_state = ST_ERROR;
          // A failed partial reload keeps the done line that the full image earned.
          if (!partialRun_ff) nxt_doneRel = 1'b0;
          if (crcError) nxt_status = 1'b0;
        end else if (loadOk) begin
          nxt_state = ST_WAIT_DONE;
          nxt_clearCnt = '0;
          // A full load frees the partial line too, or the unit would hold its own gate low.
          nxt_partialDone = 1'b1;
          if (!partialRun_ff) nxt_doneRel = 1'b1;
        end
      end
      ST_WAIT_DONE: begin
        // Another device may hold the shared line low to align start-up.
        // The synchronisers still show the lines from before the load until they refill.
        if (clearCnt_ff != `CLEAR_CNT_W'(`SETTLE_CYCLES)) begin
          nxt_clearCnt = clearCnt_ff + `CLEAR_CNT_W'(1);
        end else if (doneHigh && partialHigh) begin
          nxt_state = ST_USER;
          nxt_user = 1'b1;
        end
      end
      ST_USER: begin
        if (startReq && isPartialMode(modeSync)) begin
          nxt_state = ST_LOAD;
          nxt_partialRun = 1'b1;
          nxt_partialDone = 1'b0;
        end
      end
      ST_ERROR: begin
        nxt_state = ST_ERROR;
      end
      default: begin
        nxt_state = ST_ERROR;
      end
    endcase
  end

  // Reset clears every flag asynchronously; only a reset ends done or user mode.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= ST_CLEAR;
      clearCnt_ff <= '0;
      err_ff <= `ERR_NONE;
      partialRun_ff <= 1'b0;
      partialDone_ff <= 1'b0;
      status_ff <= 1'b0;
      user_ff <= 1'b0;
      doneRel_ff <= 1'b0;
      mode_ff <= `MODE_IDLE;
    end else begin
      state_ff <= nxt_state;
      clearCnt_ff <= nxt_clearCnt;
      err_ff <= nxt_err;
      partialRun_ff <= nxt_partialRun;
      partialDone_ff <= nxt_partialDone;
      status_ff <= nxt_status;
      user_ff <= nxt_user;
      doneRel_ff <= nxt_doneRel;
      mode_ff <= nxt_mode;
    end
  end

  always_comb begin
    nxt_csn = ~(strapSync[`STRAP_GATE_BIT] ? pinSync[4] : pinSync[5]);
    nxt_route = pinSync[6];
    nxt_jtagOut = pinSync[6] ? jtagSync : 3'h0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      csn_ff <= 1'b1;
      route_ff <= 1'b0;
      jtagOut_ff <= 3'h0;
    end else begin
      csn_ff <= nxt_csn;
      route_ff <= nxt_route;
      jtagOut_ff <= nxt_jtagOut;
    end
  end

  // Open-drain pins only ever pull low, so their data level is a flip-flop held at zero.
  always_comb begin
    nxt_odLevel = 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      odLevel_ff <= 1'b0;
    end else begin
      odLevel_ff <= nxt_odLevel;
    end
  end

  assign config_error_code = err_ff;
  // Open drain: the enable is low while the pin is pulled low.
  assign config_done_out = odLevel_ff;
  assign config_done_oe_n = doneRel_ff;
  assign partial_reconfig_done_out = odLevel_ff;
  assign partial_reconfig_done_oe_n = partialDone_ff;
  assign config_ready_status_out = odLevel_ff;
  assign config_ready_status_oe_n = status_ff;
  assign user_mode_flag = user_ff;
  assign memClear = state_ff[0];
  assign hostSelectN = csn_ff;
  assign jtagToSerdes = route_ff;
  assign serdesTck = jtagOut_ff[2];
  assign serdesTms = jtagOut_ff[1];
  assign serdesTdi = jtagOut_ff[0];
  assign activeMode = mode_ff;
endmodule
`default_nettype wire

/* File: tb/config_ctrl_model.sv */
`default_nettype none
module config_ctrl_model (
  input wire logic doneOeN,
  input wire logic partOeN,
  input wire logic holdLow,
  output logic doneLine,
  output logic partLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // Pull-ups win unless someone pulls low; holding low stalls several units together.
  assign doneLine = doneOeN && !holdLow;
  assign partLine = partOeN;
endmodule
`default_nettype wire

/* File: tb/config_unit_checker.sv */
`default_nettype none
`include "config_unit_cfg.svh"
module config_unit_checker
  import config_unit_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire config_unit_pkg::mode_sel_t config_mode_select,
  input wire logic loadStart,
  input wire logic loadComplete,
  input wire logic crcError,
  input wire logic scrubError,
  input wire logic otherError,
  input wire logic config_done_in,
  input wire logic partial_reconfig_done_in,
  input wire config_unit_pkg::err_code_t config_error_code,
  input wire logic config_done_oe_n,
  input wire logic partial_reconfig_done_oe_n,
  input wire logic config_ready_status_oe_n,
  input wire logic user_mode_flag
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_start(m, ok);
    loadStart && config_mode_select == m && ok && config_ready_status_oe_n
      && config_error_code == 3'h0;
  endsequence
  sequence s_clean;
    loadComplete && !crcError && !scrubError && !otherError;
  endsequence
  property p_full;
    s_start(`MODE_FULL, !config_done_oe_n) ##1 s_clean |=> config_done_oe_n;
  endproperty
  a_full: assert property (p_full) else $error("done not released");
  property p_part;
    s_start(`MODE_PARTIAL, user_mode_flag) ##1 s_clean |=> partial_reconfig_done_oe_n;
  endproperty
  a_part: assert property (p_part) else $error("partial done not released");
  property p_errStick;
    config_error_code != 3'h0 |=>
      (config_error_code & $past(config_error_code)) == $past(config_error_code);
  endproperty
  a_errStick: assert property (p_errStick) else $error("error code cleared");
  property p_errNoDone;
    config_error_code != 3'h0 && !user_mode_flag |-> !config_done_oe_n ##1 !user_mode_flag;
  endproperty
  a_errNoDone: assert property (p_errNoDone) else $error("done after error");
  property p_doneStick;
    config_done_oe_n |=> config_done_oe_n;
  endproperty
  a_doneStick: assert property (p_doneStick) else $error("done dropped");
  property p_userGate;
    $rose(user_mode_flag) |-> $past(config_done_in, 3) && $past(partial_reconfig_done_in, 3);
  endproperty
  a_userGate: assert property (p_userGate) else $error("user entered with line low");
  property p_userStick;
    user_mode_flag |=> user_mode_flag;
  endproperty
  a_userStick: assert property (p_userStick) else $error("user mode dropped");
  property p_statStick;
    config_ready_status_oe_n && !crcError |=> config_ready_status_oe_n;
  endproperty
  a_statStick: assert property (p_statStick) else $error("status dropped");
endmodule
bind config_unit config_unit_checker u_chk (.mclk, .rst_n, .config_mode_select, .loadStart,
  .loadComplete, .crcError, .scrubError, .otherError, .config_done_in,
  .partial_reconfig_done_in, .config_error_code, .config_done_oe_n,
  .partial_reconfig_done_oe_n, .config_ready_status_oe_n, .user_mode_flag);
`default_nettype wire

/* File: tb/config_unit_tb.sv */
`default_nettype none
`include "config_unit_cfg.svh"
module config_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import config_unit_pkg::*;
  logic mclk, rst_n, clkSel, byp, serSel, hCsn, tCsn, start, cmpl, crc, scrub, oth, tdi;
  logic holdLow, doneIn, partIn, selHost, bypd, doneOeN, partOeN, statOeN, userMode;
  logic memClr, hsn, j2s, sTdi, sTck, sTms, doneOut, partOut, statOut;
  logic [2:0] strap;
  mode_sel_t mode, actMode;
  err_code_t errCode;
  int badCount, nChecks;
  // Row: clkSel, byp, strap[0], hCsn, tCsn, serSel, tdi, then five expected outputs.
  logic [11:0] rows [4] = '{12'h0A0, 12'hEFF, 12'h74A, 12'h934};
  config_ctrl_model u_ctrl (.doneOeN(doneOeN), .partOeN(partOeN), .holdLow(holdLow),
    .doneLine(doneIn), .partLine(partIn));
  config_unit u_dut (.mclk(mclk), .rst_n(rst_n), .config_clock_select(clkSel),
    .config_sysclk_bypass(byp), .config_mode_select(mode), .test_strap(strap),
    .serdes_test_select(serSel), .host_chip_select_n(hCsn), .testChipSelectN(tCsn),
    .loadStart(start), .loadComplete(cmpl), .crcError(crc), .scrubError(scrub),
    .otherError(oth), .config_done_in(doneIn), .partial_reconfig_done_in(partIn),
    .jtagTck(tdi), .jtagTms(tdi), .jtagTdi(tdi), .selHostClk(selHost),
    .sysclkBypassed(bypd), .config_error_code(errCode), .config_done_out(doneOut),
    .config_done_oe_n(doneOeN), .partial_reconfig_done_out(partOut),
    .partial_reconfig_done_oe_n(partOeN), .config_ready_status_out(statOut),
    .config_ready_status_oe_n(statOeN), .user_mode_flag(userMode), .memClear(memClr),
    .hostSelectN(hsn), .jtagToSerdes(j2s), .serdesTck(sTck), .serdesTms(sTms),
    .serdesTdi(sTdi),
    .activeMode(actMode));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tallyAndFinish;
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic doReset;
    rst_n = 1'b0;
    repeat (12) @(negedge mclk);
    chk({2'h0, doneOeN, partOeN, statOeN, userMode, hsn, memClr}, 8'h03);
    chk({5'h00, errCode}, 8'h00);
    chk({5'h00, doneOut, partOut, statOut}, 8'h00);
    rst_n = 1'b1;
  endtask
  task automatic waitReady;
    int i;
    for (i = 0; i < 60 && statOeN !== 1'b1; i++) @(negedge mclk);
    chk({6'h00, statOeN, i == `CLEAR_CYCLES}, 8'h03);
    if (statOeN !== 1'b1) tallyAndFinish;
  endtask
  task automatic load(input mode_sel_t m, input logic [2:0] e);
    // The mode pins pass two flip-flops, so they settle before the start pulse.
    mode = m;
    repeat (2) @(negedge mclk);
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    cmpl = 1'b1;
    {oth, scrub, crc} = e;
    @(negedge mclk);
    cmpl = 1'b0;
    {oth, scrub, crc} = 3'h0;
    @(negedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    rst_n = 1'b0;
    {clkSel, byp, serSel, tCsn, start, cmpl, crc, scrub, oth, tdi} = 10'h000;
    hCsn = 1'b1;
    holdLow = 1'b1;
    strap = 3'h0;
    mode = 4'h0;
    badCount = 0;
    nChecks = 0;
    doReset;
    waitReady;
    load(`MODE_IDLE, 3'h0);
    chk({7'h00, doneOeN}, 8'h00);
    load(`MODE_FULL, 3'h0);
    repeat (8) @(negedge mclk);
    chk({6'h00, doneOeN, userMode}, 8'h02);
    holdLow = 1'b0;
    for (int i = 0; i < 20 && userMode !== 1'b1; i++) @(negedge mclk);
    chk({7'h00, userMode}, 8'h01);
    if (userMode !== 1'b1) tallyAndFinish;
    load(`MODE_PARTIAL, 3'h0);
    chk({actMode, 1'b0, doneOeN, partOeN, userMode}, {`MODE_PARTIAL, 4'h7});
    for (int r = 0; r < 4; r++) begin
      {clkSel, byp, strap[0], hCsn, tCsn, serSel, tdi} = rows[r][11:5];
      repeat (5) @(negedge mclk);
      chk({3'h0, selHost, bypd, hsn, j2s, sTdi}, {3'h0, rows[r][4:0]});
      chk({6'h00, sTck, sTms}, {6'h00, {2{rows[r][0]}}});
    end
    // Error and completion land together: the error must win, and it sticks.
    for (int k = 0; k < 3; k++) begin
      doReset;
      waitReady;
      load(`MODE_FULL, 3'h1 << k);
      load(`MODE_FULL, 3'h0);
      chk({2'h0, errCode, doneOeN, statOeN, userMode}, {2'h0, 3'h1 << k, 1'b0, k != 0, 1'b0});
    end
    tallyAndFinish;
  end
endmodule
`default_nettype wire
